// ==== inc/srfa_pkg.sv ====
// Purpose: Constants and types for the receive STS-3 framing alignment block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Overview of operation follows
package srfa_pkg;
    localparam logic [15:0] STATUS_IDX   = 16'h1107;
    localparam logic [15:0] EVENT_IDX    = 16'h110B;
    localparam logic [15:0] THRESH_IDX   = 16'h112B;
    localparam logic [15:0] ENABLE_IDX   = 16'h1113;
    localparam logic [15:0] STATUS_ADDR  = 16'(STATUS_IDX * 4);
    localparam logic [15:0] EVENT_ADDR   = 16'(EVENT_IDX * 4);
    localparam logic [15:0] THRESH_ADDR  = 16'(THRESH_IDX * 4);
    localparam logic [15:0] ENABLE_ADDR  = 16'(ENABLE_IDX * 4);
    localparam logic [3:0]  THRESH_RESET = 4'h8;
    localparam logic [7:0]  ENABLE_RESET = 8'hFF;
    localparam logic [3:0]  START_GOOD   = 4'h2;
    localparam logic [2:0]  ERR_LIMIT    = 3'h4;
    localparam int          BIT_LOS      = 0;
    localparam int          BIT_SEF      = 1;
    localparam int          BIT_LOF      = 2;
    localparam int          BIT_B1       = 3;
    localparam int          BIT_B2       = 4;
    localparam int          BIT_REI      = 5;
    localparam int          BIT_SD       = 6;
    localparam int          BIT_SF       = 7;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        ST_START   = 3'b001,
        ST_LOF     = 3'b010,
        ST_INFRAME = 3'b100
    } srfa_state_e;

    typedef struct packed {
        logic rdiL;
        logic s1Unstable;
        logic k1k2Unstable;
        logic sf;
        logic sd;
        logic los;
    } srfa_defect_s;

    typedef struct packed {
        logic reiL;
        logic b2Err;
        logic b1Err;
    } srfa_error_s;
endpackage : srfa_pkg

// ==== hw/srfa_top.sv ====
// Purpose: Receive STS-3 framing alignment machine with status and interrupt registers
// Assumes: Frame tick, framing error and defect inputs come from logic on the same clock
// Notes:   Registers reached over AXI4-Lite; 8-bit values sit in the low data bits
`timescale 1ns/1ps
module srfa_top (
    input  wire logic                  clock,        // 20 MHz clock
    input  wire logic                  rst_n,        // Synchronous reset, active low
    input  wire logic                  frameTick,    // One pulse per received frame
    input  wire logic                  frameErr,     // Framing byte error in that frame
    input  wire srfa_pkg::srfa_defect_s defects,     // Other defect levels
    input  wire srfa_pkg::srfa_error_s  errors,      // Error detection pulses
    input  wire logic [15:0]           s_axi_awaddr, // Write address
    input  wire logic                  s_axi_awvalid,// Write address valid
    output logic                       s_axi_awready,// Write address ready
    input  wire logic [31:0]           s_axi_wdata,  // Write data
    input  wire logic [3:0]            s_axi_wstrb,  // Write strobes
    input  wire logic                  s_axi_wvalid, // Write data valid
    output logic                       s_axi_wready, // Write data ready
    output logic [1:0]                 s_axi_bresp,  // Write response
    output logic                       s_axi_bvalid, // Write response valid
    input  wire logic                  s_axi_bready, // Write response ready
    input  wire logic [15:0]           s_axi_araddr, // Read address
    input  wire logic                  s_axi_arvalid,// Read address valid
    output logic                       s_axi_arready,// Read address ready
    output logic [31:0]                s_axi_rdata,  // Read data
    output logic [1:0]                 s_axi_rresp,  // Read response
    output logic                       s_axi_rvalid, // Read data valid
    input  wire logic                  s_axi_rready, // Read data ready
    output logic                       lofDefect,    // Loss of frame declared
    output logic                       sefDefect,    // Severely errored frame declared
    output logic                       intN          // Interrupt request, active low
);
    srfa_pkg::srfa_state_e state;
    srfa_pkg::srfa_state_e next_state;
    logic [3:0]  goodCnt;
    logic [3:0]  next_goodCnt;
    logic [2:0]  errCnt;
    logic [2:0]  next_errCnt;
    logic [3:0]  threshold;
    logic [7:0]  intEnable;
    logic [7:0]  statusByte;
    logic [7:0]  evtStat;
    logic [7:0]  events;
    logic [7:0]  readClear;
    logic [2:0]  prevDefects;
    logic        next_lof;
    logic        next_sef;
    logic [15:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic        awGot;
    logic        wGot;
    logic        doWrite;
    logic        doRead;
    logic [31:0] rdValue;
    logic        rdMapped;
    logic        wrMapped;

    // Alignment machine next state
    always_comb begin
        next_state   = state;
        next_goodCnt = goodCnt;
        next_errCnt  = errCnt;
        if (frameTick) begin
            if (frameErr) begin
                next_goodCnt = 4'h0;
                next_errCnt  = (errCnt == srfa_pkg::ERR_LIMIT) ? errCnt : errCnt + 3'h1;
            end else begin
                next_errCnt  = 3'h0;
                next_goodCnt = (goodCnt == 4'hF) ? goodCnt : goodCnt + 4'h1;
            end
            case (state)
                srfa_pkg::ST_START: begin
                    if (!frameErr && (goodCnt + 4'h1 == srfa_pkg::START_GOOD)) begin
                        next_state   = srfa_pkg::ST_LOF;
                        next_goodCnt = 4'h0;
                    end
                end
                srfa_pkg::ST_LOF: begin
                    if (frameErr && (errCnt + 3'h1 == srfa_pkg::ERR_LIMIT)) begin
                        next_state  = srfa_pkg::ST_START;
                        next_errCnt = 3'h0;
                    end else if (!frameErr && ({1'b0, goodCnt} + 5'h01 >= {1'b0, threshold})) begin
                        next_state   = srfa_pkg::ST_INFRAME;
                        next_goodCnt = 4'h0;
                    end
                end
                srfa_pkg::ST_INFRAME: begin
                    if (frameErr && (errCnt + 3'h1 == srfa_pkg::ERR_LIMIT)) begin
                        next_state  = srfa_pkg::ST_START;
                        next_errCnt = 3'h0;
                    end
                end
                default: begin
                    next_state = srfa_pkg::ST_START;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state   <= srfa_pkg::ST_START;
            goodCnt <= 4'h0;
            errCnt  <= 3'h0;
        end else begin
            state   <= next_state;
            goodCnt <= next_goodCnt;
            errCnt  <= next_errCnt;
        end
    end

    assign next_lof = (next_state != srfa_pkg::ST_INFRAME);
    assign next_sef = (next_state == srfa_pkg::ST_START);

    // Defect flags follow the machine state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lofDefect <= 1'b1;
            sefDefect <= 1'b1;
        end else begin
            lofDefect <= next_lof;
            sefDefect <= next_sef;
        end
    end

    // Status byte, bit 7 down to bit 0
    assign statusByte = {defects.rdiL, defects.s1Unstable, defects.k1k2Unstable, defects.sf,
                         defects.sd, lofDefect, sefDefect, defects.los};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prevDefects <= 3'h0;
        end else begin
            prevDefects <= {defects.sf, defects.sd, defects.los};
        end
    end

    // Event sources for the interrupt status byte
    always_comb begin
        events                       = 8'h00;
        events[srfa_pkg::BIT_LOS]    = defects.los != prevDefects[0];
        events[srfa_pkg::BIT_SEF]    = next_sef != sefDefect;
        events[srfa_pkg::BIT_LOF]    = next_lof != lofDefect;
        events[srfa_pkg::BIT_B1]     = errors.b1Err;
        events[srfa_pkg::BIT_B2]     = errors.b2Err;
        events[srfa_pkg::BIT_REI]    = errors.reiL;
        events[srfa_pkg::BIT_SD]     = defects.sd != prevDefects[1];
        events[srfa_pkg::BIT_SF]     = defects.sf != prevDefects[2];
    end

    assign readClear = (doRead && s_axi_araddr == srfa_pkg::EVENT_ADDR) ? evtStat : 8'h00;

    // Sticky events; a new event wins over a read clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            evtStat <= 8'h00;
        end else begin
            evtStat <= (evtStat & ~readClear) | events;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            intN <= 1'b1;
        end else begin
            intN <= ~|(evtStat & intEnable);
        end
    end

    // Write channel
    assign doWrite  = awGot && wGot && !s_axi_bvalid;
    assign wrMapped = (wrAddr == srfa_pkg::STATUS_ADDR) || (wrAddr == srfa_pkg::EVENT_ADDR) ||
                      (wrAddr == srfa_pkg::THRESH_ADDR) || (wrAddr == srfa_pkg::ENABLE_ADDR);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awGot         <= 1'b0;
            wGot          <= 1'b0;
            wrAddr        <= 16'h0000;
            wrData        <= 32'h0000_0000;
            wrStrb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= srfa_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awGot         <= 1'b1;
                wrAddr        <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wGot         <= 1'b1;
                wrData       <= s_axi_wdata;
                wrStrb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                awGot        <= 1'b0;
                wGot         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? srfa_pkg::RESP_OKAY : srfa_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Writable control registers; status and event bytes ignore writes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            threshold <= srfa_pkg::THRESH_RESET;
            intEnable <= srfa_pkg::ENABLE_RESET;
        end else if (doWrite && wrStrb[0]) begin
            if (wrAddr == srfa_pkg::THRESH_ADDR) begin
                threshold <= wrData[3:0];
            end
            if (wrAddr == srfa_pkg::ENABLE_ADDR) begin
                intEnable <= wrData[7:0];
            end
        end
    end

    // Read channel
    assign doRead = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rdValue  = 32'h0000_0000;
        rdMapped = 1'b1;
        case (s_axi_araddr)
            srfa_pkg::STATUS_ADDR: begin
                rdValue[7:0] = statusByte;
            end
            srfa_pkg::EVENT_ADDR: begin
                rdValue[7:0] = evtStat;
            end
            srfa_pkg::THRESH_ADDR: begin
                rdValue[3:0] = threshold;
            end
            srfa_pkg::ENABLE_ADDR: begin
                rdValue[7:0] = intEnable;
            end
            default: begin
                rdMapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= srfa_pkg::RESP_OKAY;
        end else begin
            if (doRead) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdValue;
                s_axi_rresp   <= rdMapped ? srfa_pkg::RESP_OKAY : srfa_pkg::RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_reset_start: assert property (!$past(rst_n) |-> state == srfa_pkg::ST_START && sefDefect && lofDefect)
        else $error("Machine not in start state after reset");
    a_start_flags: assert property (state == srfa_pkg::ST_START
        |-> sefDefect && lofDefect && statusByte[2:1] == 2'b11)
        else $error("Start state flags not both set");
    a_two_good_exit: assert property (state == srfa_pkg::ST_START ##0 (frameTick && !frameErr)[*1]
        ##1 (state == srfa_pkg::ST_START) ##0 (frameTick && !frameErr) |=> state == srfa_pkg::ST_LOF)
        else $error("Two good frames did not leave the start state");
    a_no_early_exit: assert property (state == srfa_pkg::ST_LOF && $past(state) == srfa_pkg::ST_START
        |-> $past(goodCnt) == 4'h1 && $past(frameTick) && !$past(frameErr))
        else $error("Start state left without two good frames");
    a_sef_clear_bits: assert property ($fell(sefDefect) && state == srfa_pkg::ST_LOF
        |-> lofDefect && statusByte[2:1] == 2'b10)
        else $error("Status bits wrong on leaving start state");
    a_sef_event: assert property ($fell(sefDefect) |-> evtStat[srfa_pkg::BIT_SEF])
        else $error("SEF change event not recorded");
    a_int_low: assert property ($fell(sefDefect) && intEnable[srfa_pkg::BIT_SEF] |=> !intN)
        else $error("Interrupt request not driven low");
    a_four_errors: assert property (state == srfa_pkg::ST_LOF && frameTick && frameErr && errCnt == 3'h3
        |=> state == srfa_pkg::ST_START && sefDefect)
        else $error("Four errored frames did not redeclare SEF");
    a_insync_exit: assert property (state == srfa_pkg::ST_LOF && frameTick && !frameErr && errCnt != 3'h3
        && {1'b0, goodCnt} + 5'h01 >= {1'b0, threshold} |=> state == srfa_pkg::ST_INFRAME && !lofDefect)
        else $error("Threshold of good frames did not clear LOF");
    a_status_read: assert property (doRead && s_axi_araddr == srfa_pkg::STATUS_ADDR
        |=> s_axi_rdata == {24'h00_0000, $past(statusByte)})
        else $error("Status byte read wrong");
    a_b1_event: assert property (errors.b1Err |=> evtStat[srfa_pkg::BIT_B1])
        else $error("B1 event not recorded");
    a_read_clear: assert property (doRead && s_axi_araddr == srfa_pkg::EVENT_ADDR && events == 8'h00
        |=> evtStat == 8'h00)
        else $error("Event byte not cleared by read");
    a_int_release: assert property ((evtStat & intEnable) == 8'h00 |=> intN)
        else $error("Interrupt request not released");
endmodule : srfa_top

// ==== testbench/srfa_line_model.sv ====
// Purpose: Remote line source sending frame ticks with good or errored framing bytes
// Assumes: Bench changes run, gap and errIn just after a rising edge
// Notes:   frameErr toggles between ticks, where it carries no meaning
`timescale 1ns/1ps
module srfa_line_model (
    input  wire logic        clock,     // Bench clock
    input  wire logic        rst_n,     // Synchronous reset, active low
    input  wire logic        run,       // Send frames while high
    input  wire logic [3:0]  gap,       // Idle cycles between ticks, 0 for a tick every cycle
    input  wire logic        errIn,     // Coming frames carry framing errors
    output logic             frameTick, // One pulse per frame
    output logic             frameErr,  // Framing error of that frame
    output logic [15:0]      sent       // Frames sent so far
);
    logic [3:0] cnt;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt       <= 4'h0;
            frameTick <= 1'h0;
            frameErr  <= 1'h0;
            sent      <= 16'h0000;
        end else if (run && cnt >= gap) begin
            cnt       <= 4'h0;
            frameTick <= 1'h1;
            frameErr  <= errIn;
            sent      <= sent + 16'h0001;
        end else begin
            cnt       <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
            frameTick <= 1'h0;
            frameErr  <= ~frameErr;
        end
    end
endmodule : srfa_line_model

// ==== testbench/srfa_top_tb.sv ====
// Purpose: Self-checking bench for the framing alignment block and its registers
// Assumes: AXI4-Lite master waits on handshakes; frames come from the line model
// Notes:   Random defect and error patterns come from a fixed-seed LFSR
`timescale 1ns/1ps
module srfa_top_tb;
    logic clock, rst_n, run, errIn, frameTick, frameErr, lofDefect, sefDefect, intN;
    logic [3:0] gap;
    logic [15:0] sent, s_axi_awaddr, s_axi_araddr;
    srfa_pkg::srfa_defect_s defects, pd;
    srfa_pkg::srfa_error_s errors;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, lfsr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] ev;
    int err_total, compares, cyc;

    srfa_top srfa_top_i (.clock, .rst_n, .frameTick, .frameErr, .defects, .errors, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lofDefect, .sefDefect, .intN);
    srfa_line_model srfa_line_model_i (.clock, .rst_n, .run, .gap, .errIn, .frameTick, .frameErr, .sent);

    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function automatic logic [31:0] exp_status(input srfa_pkg::srfa_defect_s d, input logic lof, input logic sef);
        return {24'h00_0000, d.rdiL, d.s1Unstable, d.k1k2Unstable, d.sf, d.sd, lof, sef, d.los};
    endfunction : exp_status
    function automatic logic [7:0] exp_event(input srfa_pkg::srfa_defect_s d, input srfa_pkg::srfa_defect_s p,
                                             input srfa_pkg::srfa_error_s e);
        return {d.sf ^ p.sf, d.sd ^ p.sd, e.reiL, e.b2Err, e.b1Err, 2'h0, d.los ^ p.los};
    endfunction : exp_event

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge clock);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end while (!b);
        s_axi_bready <= 1'h0;
    endtask : axi_wr
    task automatic rdchk(input logic [15:0] a, input logic [31:0] ex, input string nm);
        logic ar, v;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge clock);
            ar = s_axi_arready;
            v = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clock);
            if (ar) s_axi_arvalid <= 1'h0;
        end while (!v);
        s_axi_rready <= 1'h0;
        chk(nm, ex, rd);
    endtask : rdchk
    task automatic send(input int n, input logic e);
        logic [15:0] t;
        t = sent + 16'(n);
        lfsr = nxt(lfsr);
        @(posedge clock);
        errIn <= e;
        gap <= lfsr[3:0] | 4'h1;
        run <= 1'h1;
        while (sent !== t) @(negedge clock);
        @(posedge clock);
        run <= 1'h0;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask : send
    // Back-to-back frames, one tick on each of n clocks
    task automatic burst(input int n, input logic e);
        @(posedge clock);
        errIn <= e;
        gap <= 4'h0;
        run <= 1'h1;
        repeat (n) @(posedge clock);
        run <= 1'h0;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask : burst
    task automatic pulse_wait;
        @(posedge clock);
        errors <= 3'h0;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask : pulse_wait

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        {rst_n, run, errIn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 8'h00;
        {gap, defects, errors, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        lfsr = 32'h4a5e_6b8c;
        err_total = 0;
        compares = 0;
        cyc = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        @(negedge clock);
        chk("lofDefect", 1, lofDefect);
        chk("sefDefect", 1, sefDefect);
        chk("intN", 1, intN);
        rdchk(srfa_pkg::STATUS_ADDR, exp_status(6'h00, 1'h1, 1'h1), "status");
        rdchk(srfa_pkg::EVENT_ADDR, 0, "event");
        rdchk(srfa_pkg::THRESH_ADDR, 32'(srfa_pkg::THRESH_RESET), "threshold");
        rdchk(srfa_pkg::ENABLE_ADDR, 32'(srfa_pkg::ENABLE_RESET), "enable");
        rdchk(16'h0010, 0, "unmapped data");
        chk("unmapped rresp", 32'(srfa_pkg::RESP_SLVERR), rs);
        $display("test reset done");
        send(1, 1'h0);
        send(1, 1'h1);
        send(1, 1'h0);
        chk("sefDefect", 1, sefDefect);
        send(1, 1'h0);
        chk("sefDefect", 0, sefDefect);
        chk("lofDefect", 1, lofDefect);
        chk("intN", 0, intN);
        rdchk(srfa_pkg::STATUS_ADDR, exp_status(6'h00, 1'h1, 1'h0), "status");
        rdchk(srfa_pkg::EVENT_ADDR, 32'h0000_0002, "event");
        @(negedge clock);
        chk("intN", 1, intN);
        rdchk(srfa_pkg::EVENT_ADDR, 0, "event");
        $display("test start exit done");
        send(3, 1'h1);
        send(1, 1'h0);
        send(3, 1'h1);
        chk("sefDefect", 0, sefDefect);
        send(1, 1'h1);
        chk("sefDefect", 1, sefDefect);
        chk("lofDefect", 1, lofDefect);
        rdchk(srfa_pkg::EVENT_ADDR, 32'h0000_0002, "event");
        $display("test redeclare done");
        axi_wr(srfa_pkg::THRESH_ADDR, 32'h0000_0003, rs);
        chk("bresp", 32'(srfa_pkg::RESP_OKAY), rs);
        rdchk(srfa_pkg::THRESH_ADDR, 32'h0000_0003, "threshold");
        burst(2, 1'h0);
        chk("sefDefect", 0, sefDefect);
        send(2, 1'h0);
        chk("lofDefect", 1, lofDefect);
        send(1, 1'h0);
        chk("lofDefect", 0, lofDefect);
        rdchk(srfa_pkg::EVENT_ADDR, 32'h0000_0006, "event");
        axi_wr(srfa_pkg::STATUS_ADDR, 32'h0000_00FF, rs);
        rdchk(srfa_pkg::STATUS_ADDR, exp_status(6'h00, 1'h0, 1'h0), "status");
        axi_wr(16'h0008, 32'h0000_0001, rs);
        chk("unmapped bresp", 32'(srfa_pkg::RESP_SLVERR), rs);
        $display("test in-frame done");
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            pd = defects;
            ev = exp_event(lfsr[5:0], pd, lfsr[10:8]);
            @(posedge clock);
            defects <= lfsr[5:0];
            errors <= lfsr[10:8];
            pulse_wait();
            chk("intN", 32'(ev == 8'h00), intN);
            rdchk(srfa_pkg::STATUS_ADDR, exp_status(defects, 1'h0, 1'h0), "status");
            rdchk(srfa_pkg::EVENT_ADDR, 32'(ev), "event");
        end
        $display("test random events done");
        axi_wr(srfa_pkg::ENABLE_ADDR, 32'h0000_0000, rs);
        @(posedge clock);
        errors <= 3'h1;
        pulse_wait();
        chk("masked intN", 1, intN);
        rdchk(srfa_pkg::EVENT_ADDR, 32'h0000_0008, "event");
        s_axi_wstrb <= 4'h0;
        axi_wr(srfa_pkg::ENABLE_ADDR, 32'h0000_00FF, rs);
        rdchk(srfa_pkg::ENABLE_ADDR, 0, "enable");
        s_axi_wstrb <= 4'hF;
        axi_wr(srfa_pkg::ENABLE_ADDR, 32'h0000_00FF, rs);
        rdchk(srfa_pkg::ENABLE_ADDR, 32'h0000_00FF, "enable");
        $display("test mask done");
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        @(negedge clock);
        chk("lofDefect", 1, lofDefect);
        chk("sefDefect", 1, sefDefect);
        chk("intN", 1, intN);
        rdchk(srfa_pkg::THRESH_ADDR, 32'(srfa_pkg::THRESH_RESET), "threshold");
        $display("test mid reset done");
        wrap_up();
    end
endmodule : srfa_top_tb
